// ===== design/ppd_page_port_decoder_wait.sv
// Function
// - System RAM at C800-CBFF, all chips enabled
// - Bits 0-4 row, 5-9 column, 10-15 page
// - RAM write enable low only on MWRITE
// - Page decoder needs high nibble 1100
// - Bits 11:10 pick four active-low selects
// - Memory select when any page active
// - Boot overlay maps ROM to page 0
// - Page decoder off during input/output
// - Ready low from mid-sync to phase-2
// - Ports need bits 15-11 all ones
// - Bits 8-10 select one of eight strobes
// - Input decoder needs data-in and input status
// - Output decoder needs output status and write
// - Internal-bus select for inputs F8-FB
// - Interrupt acknowledge disables all decoders
// - Output strobes feed scroll, parallel, UARTs
// - Port F8 output latches bit 4 RTS
// - Input strobes select listed read sources
// - Input FD resets parallel handshake
// - Boot overlay low for four fetches
`timescale 1ns/1ps
`include "ppd_defines.svh"
module ppd_page_port_decoder_wait
    import ppd_pkg::*;
#(
    parameter bit INTA_OPTION = 1'b1
) (
    // Clock and synchronous reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,

    // Bus address, status and data straight from the pins
    input  wire logic [15:0] addr_i,
    input  wire ppd_status_s status_i,
    input  wire logic [7:0]  data_i,

    // Memory pages and RAM control
    output ppd_pages_s       pages_o,
    output logic             mem_sel_o,
    output logic             ram_we_n_o,
    output logic [9:0]       ram_addr_o,
    output logic             ram_cs_n_o,

    // Raw port strobes, bit n is port F8 plus n, and internal-bus select
    output logic [7:0]       port_in_n_o,
    output logic [7:0]       port_out_n_o,
    output logic             int_sel_o,

    // Named output strobes and the request-to-send latch
    output logic             scroll_load_o,
    output logic             parallel_port_out_o,
    output logic             cassette_interface_tx_o,
    output logic             ctrl_load_o,
    output logic             serial_interface_tx_o,
    output logic             serial_rts_o,

    // Named input strobes
    output logic             sense_sw_rd_o,
    output logic             scroll_stat_rd_o,
    output logic             keyboard_rd_o,
    output logic             parallel_port_in_o,
    output logic             parallel_port_hs_clr_o,
    output logic             cassette_interface_rx_o,
    output logic             port_stat_rd_o,
    output logic             serial_interface_rx_o,
    output logic             serial_interface_stat_o,

    // Boot overlay and processor ready
    output logic             boot_overlay_n_o,
    output logic             processor_ready_out_o
);
    // Timing model: every pin input is two cycles old when decoded, so all
    // selects lag the bus by two clocks; the clock stands in for phase 2.
    // Decode is pure logic on the synchronised copies; only the wait flag,
    // the boot counter, the RTS latch and the edge samples hold state.
    // Registered copies keep skewed pin edges out of the decode, traded
    // against two clocks of latency on every select.
    // Limitation: a status or address held for less than one clock period
    // may be missed entirely, since nothing stretches a short pulse.

    // Pin-side status, address and data pass two flops before any decode
    ppd_status_s stat_s1_q;
    ppd_status_s stat_q;
    logic [15:0] addr_s1_q;
    logic [15:0] addr_q;
    logic [7:0]  data_s1_q;
    logic [7:0]  data_q;

    // Boot counter, previous-cycle samples, wait flag and RTS latch
    logic [2:0]  fetch_cnt_q;
    logic [2:0]  fetch_cnt_d;
    logic        pdbin_prev_q;
    logic        psync_prev_q;
    logic        wait_q;
    logic        wait_d;
    logic        rts_q;
    logic        rts_d;

    // First status stage; nothing but the second stage reads it
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            stat_s1_q <= '0;
        end else begin
            stat_s1_q <= status_i;
        end
    end

    // Second status stage feeds all decode
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            stat_q <= '0;
        end else begin
            stat_q <= stat_s1_q;
        end
    end

    // First address stage
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            addr_s1_q <= 16'h0000;
        end else begin
            addr_s1_q <= addr_i;
        end
    end

    // Second address stage; address and status move together
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            addr_q <= 16'h0000;
        end else begin
            addr_q <= addr_s1_q;
        end
    end

    // First data stage
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            data_s1_q <= 8'h00;
        end else begin
            data_s1_q <= data_i;
        end
    end

    // Second data stage, read only by the RTS latch
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            data_q <= 8'h00;
        end else begin
            data_q <= data_s1_q;
        end
    end

    // Synchronised status, named for the decode below
    wire st_sinp   = stat_q.sinp;
    wire st_sout   = stat_q.sout;
    wire st_sinta  = stat_q.sinta;
    wire st_mwrite = stat_q.mwrite;
    wire st_psync  = stat_q.psync;
    wire st_pdbin  = stat_q.pdbin;
    wire st_pwr    = stat_q.pwr;

    // Address fields used by the decoders
    wire [3:0] addr_hi_nib  = addr_q[15:12];
    wire [5:0] addr_page    = addr_q[15:10];
    wire [4:0] addr_port_hi = addr_q[15:11];
    wire [2:0] addr_port_lo = addr_q[10:8];
    wire [1:0] addr_pg_sel  = addr_q[11:10];

    // Acknowledge gating, only with the option fitted
    wire inta_off = INTA_OPTION && st_sinta;
    // Counter saturates at four, so the overlay never comes back
    wire boot_n   = (fetch_cnt_q >= `PPD_BOOT_FETCHES);
    // Any input or output cycle
    wire io_cycle = st_sinp | st_sout;

    wire hi_is_c  = (addr_hi_nib == `PPD_MEM_HI_NIB);
    wire boot_pg0 = !boot_n && (addr_page == `PPD_BOOT_HI);
    // C pages suppressed while the overlay is low
    wire c_pg_ok  = hi_is_c && boot_n;
    wire pg_en_io = !io_cycle && !inta_off;
    // Acknowledge gating also stops the page decoder
    wire pg_en    = pg_en_io && (c_pg_ok || boot_pg0);
    // Page zero under the overlay is the first ROM page
    wire [1:0] pg = boot_pg0 ? `PPD_PAGE_ROM0 :
                    addr_pg_sel;

    wire hit_rom0   = pg_en && (pg == `PPD_PAGE_ROM0);
    wire hit_rom1   = pg_en && (pg == `PPD_PAGE_ROM1);
    wire hit_sysram = pg_en && (pg == `PPD_PAGE_SYSRAM);
    wire hit_disp   = pg_en && (pg == `PPD_PAGE_DISP);

    assign pages_o.rom0_n   = !hit_rom0;
    assign pages_o.rom1_n   = !hit_rom1;
    assign pages_o.sysram_n = !hit_sysram;
    assign pages_o.disp_n   = !hit_disp;

    assign mem_sel_o  = hit_rom0 || hit_rom1 ||
                        hit_sysram || hit_disp;
    // RAM chip enable, shared by all eight chips
    assign ram_cs_n_o = !hit_sysram;
    // Row and column; the page bits went to the decoder
    assign ram_addr_o = addr_q[9:0];
    // Write only on status, otherwise read mode
    assign ram_we_n_o = !(st_mwrite && hit_sysram);

    // Port range
    // Acknowledge blocks port decode as well as page decode
    wire port_hit = (addr_port_hi == `PPD_PORT_HI) && !inta_off;
    wire in_en    = port_hit && st_pdbin && st_sinp;
    wire out_en   = port_hit && st_sout && st_pwr;

    // Eight strobes per decoder
    // One comparator per port number serves both decoders
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_port
            wire num_hit = (addr_port_lo == 3'(g));
            assign port_in_n_o[g]  = !(in_en && num_hit);
            assign port_out_n_o[g] = !(out_en && num_hit);
        end
    endgenerate

    // Active-high views of the strobes for the named outputs;
    // inverting once here keeps the named outputs free of negations
    wire [7:0] in_hit  = ~port_in_n_o;
    wire [7:0] out_hit = ~port_out_n_o;

    assign int_sel_o = |in_hit[`PPD_PORT_FB:`PPD_PORT_F8];

    // Output targets
    // Scroll position load
    assign scroll_load_o           = out_hit[`PPD_PORT_FE];
    // Parallel output data
    assign parallel_port_out_o     = out_hit[`PPD_PORT_FD];
    // Cassette transmitter
    assign cassette_interface_tx_o = out_hit[`PPD_PORT_FB];
    // Parallel and cassette control bits
    assign ctrl_load_o             = out_hit[`PPD_PORT_FA];
    // Serial transmitter
    assign serial_interface_tx_o   = out_hit[`PPD_PORT_F9];

    // Input sources
    // Sense switches
    assign sense_sw_rd_o           = in_hit[`PPD_PORT_FF];
    // Scroll status
    assign scroll_stat_rd_o        = in_hit[`PPD_PORT_FE];
    // Keyboard
    assign keyboard_rd_o           = in_hit[`PPD_PORT_FC];
    // Cassette received byte
    assign cassette_interface_rx_o = in_hit[`PPD_PORT_FB];
    // Combined port status
    assign port_stat_rd_o          = in_hit[`PPD_PORT_FA];
    // Serial received byte
    assign serial_interface_rx_o   = in_hit[`PPD_PORT_F9];
    // Serial status
    assign serial_interface_stat_o = in_hit[`PPD_PORT_F8];

    // Parallel read and handshake reset share one strobe
    assign parallel_port_in_o     = in_hit[`PPD_PORT_FD];
    assign parallel_port_hs_clr_o = in_hit[`PPD_PORT_FD];

    // RTS latch, only an output to F8 loads it
    // Data is two cycles old, the same age as the strobe
    wire rts_load = out_hit[`PPD_PORT_F8];
    assign rts_d  = rts_load ? data_q[`PPD_RTS_BIT] :
                    rts_q;
    assign serial_rts_o = rts_q;

    // Count data-in strobes, then release overlay
    wire pdbin_rise = st_pdbin && !pdbin_prev_q;
    assign fetch_cnt_d = (pdbin_rise && !boot_n) ? fetch_cnt_q + 3'h1 :
                         fetch_cnt_q;
    assign boot_overlay_n_o = boot_n;

    // Wait flag set at sync start, held until sync ends; the clock
    // stands in for phase 2, so sync falling marks the first phase-2 edge
    wire psync_rise = st_psync && !psync_prev_q;
    wire cycle_ref  = mem_sel_o || io_cycle;
    assign wait_d   = psync_rise ? 1'b1 :
                      st_psync   ? wait_q :
                                   1'b0;
    // A cycle that touches neither memory nor a port gets no wait
    // One wait per referencing cycle
    assign processor_ready_out_o = !(wait_q && cycle_ref);

    // Only these flops hold state besides the synchronisers
    // Boot counter; reset puts the overlay back on
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            fetch_cnt_q <= 3'h0;
        end else begin
            fetch_cnt_q <= fetch_cnt_d;
        end
    end

    // Data-in sample for the strobe edge, idle low after reset
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pdbin_prev_q <= 1'b0;
        end else begin
            pdbin_prev_q <= st_pdbin;
        end
    end

    // Sync sample for the start of a cycle
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            psync_prev_q <= 1'b0;
        end else begin
            psync_prev_q <= st_psync;
        end
    end

    // Wait flag
    // Reset clears the flag so ready starts high
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= wait_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rts_q <= 1'b0;
        end else begin
            rts_q <= rts_d;
        end
    end
endmodule

// ===== include/ppd_defines.svh
`ifndef PPD_DEFINES_SVH
`define PPD_DEFINES_SVH
// Memory page decode: high nibble and page numbers (addr[11:10])
`define PPD_MEM_HI_NIB      4'hc
`define PPD_PAGE_ROM0       2'h0
`define PPD_PAGE_ROM1       2'h1
`define PPD_PAGE_SYSRAM     2'h2
`define PPD_PAGE_DISP       2'h3
`define PPD_BOOT_HI         6'h00
// Port decode: addr[15:11] must be all ones
`define PPD_PORT_HI         5'h1f
// Port numbers as addr[10:8]
`define PPD_PORT_F8         3'h0
`define PPD_PORT_F9         3'h1
`define PPD_PORT_FA         3'h2
`define PPD_PORT_FB         3'h3
`define PPD_PORT_FC         3'h4
`define PPD_PORT_FD         3'h5
`define PPD_PORT_FE         3'h6
`define PPD_PORT_FF         3'h7
`define PPD_RTS_BIT         4
`define PPD_BOOT_FETCHES    3'h4
`endif

// ===== include/ppd_pkg.sv
package ppd_pkg;
    // Bus status sampled from the processor side
    typedef struct packed {
        logic sinp;
        logic sout;
        logic sinta;
        logic mwrite;
        logic psync;
        logic pdbin;
        logic pwr;
    } ppd_status_s;

    // Active-low page selects
    typedef struct packed {
        logic rom0_n;
        logic rom1_n;
        logic sysram_n;
        logic disp_n;
    } ppd_pages_s;
endpackage

// ===== sim/ppd_chk_asserts.sv
`timescale 1ns/1ps
module ppd_chk
    import ppd_pkg::*;
(
    input wire logic        clk_i, rstn_i, mem_sel_o, ram_we_n_o, ram_cs_n_o,
    input wire logic        int_sel_o, boot_overlay_n_o, processor_ready_out_o,
    input wire logic [15:0] addr_i,
    input wire ppd_status_s status_i,
    input wire ppd_pages_s  pages_o,
    input wire logic [7:0]  port_in_n_o, port_out_n_o
);
    // Mirror of the two-flop input sync, so causes line up with outputs
    logic [22:0] d1_q, d2_q;
    logic [1:0]  rv_q;
    always_ff @(posedge clk_i) begin
        d1_q <= {addr_i, status_i};
        d2_q <= d1_q;
        rv_q <= {rv_q[0], rstn_i};
    end
    wire [15:0] a = d2_q[22:7];
    wire [6:0]  s = d2_q[6:0];
    wire        ok = &rv_q;
    wire        pt = ok && &a[15:11];
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_msel_any: assert property (mem_sel_o == !(&pages_o)) else $error("msel");
    a_we_page: assert property (!ram_we_n_o |-> !ram_cs_n_o) else $error("we");
    a_io_off: assert property (ok && |s[6:5] |-> &pages_o) else $error("io");
    a_ram_pg: assert property (ok && a[15:10] == 6'h32 && !s[6:4] && boot_overlay_n_o
        |-> pages_o == 4'hd && !ram_cs_n_o) else $error("ram");
    a_boot_pg: assert property (ok && !a[15:10] && !s[6:4] && !boot_overlay_n_o
        |-> pages_o == 4'h7) else $error("boot");
    a_in_dec: assert property (pt && s[6:4] == 3'h4 && s[1]
        |-> port_in_n_o == ~(8'h1 << a[10:8])) else $error("in");
    a_out_dec: assert property (pt && s[6:4] == 3'h2 && s[0]
        |-> port_out_n_o == ~(8'h1 << a[10:8])) else $error("out");
    a_inta_off: assert property (ok && s[4] |-> &{pages_o, port_in_n_o, port_out_n_o})
        else $error("inta");
    a_int_sel: assert property (int_sel_o == !(&port_in_n_o[3:0])) else $error("isel");
    a_wait_end: assert property ($fell(processor_ready_out_o) |-> ##[1:40] processor_ready_out_o)
        else $error("wait");
    c_wait: cover property (!processor_ready_out_o);
    c_boot: cover property (!boot_overlay_n_o && !pages_o.rom0_n);
    c_fd_in: cover property (!port_in_n_o[5]);
endmodule
bind ppd_page_port_decoder_wait ppd_chk u_ppd_chk (.*);

// ===== sim/ppd_cpu_model.sv
`timescale 1ns/1ps
module ppd_cpu_model (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic start_i,
    input  wire logic ready_i,
    output logic      psync_o,
    output logic      waited_o
);
    logic [2:0] cnt_q;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cnt_q <= 3'h0;
            waited_o <= 1'b0;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q + 3'h1;
            waited_o <= waited_o | !ready_i;
        end else if (start_i) begin
            cnt_q <= 3'h1;
            waited_o <= 1'b0;
        end
    end
    // Sync held four cycles, long enough to pass the device's synchroniser
    assign psync_o = (cnt_q != 3'h0) && (cnt_q < 3'h5);
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import ppd_pkg::*;
;
    logic       clk = 0, rstn = 0, go = 0, sy, ms, we, cs, isel, rts, ovl, rdy, wt;
    logic [15:0] addr = 0;
    logic [6:0] st = 0;
    logic [7:0] data = 0, pin, pout;
    logic [8:0] ins;
    logic [4:0] outs;
    logic [9:0] ra;
    ppd_pages_s pg;
    int         errors = 0, n_compared = 0;
    initial forever #2 clk = ~clk;
    ppd_page_port_decoder_wait u_ppd_page_port_decoder_wait (
        .clk_i(clk), .rstn_i(rstn), .addr_i(addr), .data_i(data),
        .status_i(ppd_status_s'(st | {4'h0, sy, 2'h0})), .pages_o(pg), .mem_sel_o(ms),
        .ram_we_n_o(we), .ram_addr_o(ra), .ram_cs_n_o(cs), .port_in_n_o(pin),
        .port_out_n_o(pout), .int_sel_o(isel), .serial_rts_o(rts), .scroll_load_o(outs[4]),
        .parallel_port_out_o(outs[3]), .cassette_interface_tx_o(outs[2]),
        .ctrl_load_o(outs[1]), .serial_interface_tx_o(outs[0]), .sense_sw_rd_o(ins[8]),
        .scroll_stat_rd_o(ins[7]), .keyboard_rd_o(ins[6]), .parallel_port_in_o(ins[5]),
        .parallel_port_hs_clr_o(ins[4]), .cassette_interface_rx_o(ins[3]),
        .port_stat_rd_o(ins[2]), .serial_interface_rx_o(ins[1]),
        .serial_interface_stat_o(ins[0]), .boot_overlay_n_o(ovl), .processor_ready_out_o(rdy));
    ppd_cpu_model u_ppd_cpu_model (.clk_i(clk), .rstn_i(rstn), .start_i(go), .ready_i(rdy),
        .psync_o(sy), .waited_o(wt));
    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    // Four edges cover the two-cycle sync plus the registered boot counter and RTS latch
    task automatic put(input logic [15:0] a, input logic [6:0] s, input logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        st = s;
        data = d;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic conclude;
        if (errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_boot;
        put(16'hc000, 7'h00, 8'h00);
        chk("c0", 4'hf, pg);
        for (int i = 0; i < 4; i++) begin
            put(16'h0000, 7'h00, 8'h00);
            chk("p0", 4'h7, pg);
            put(16'h0000, 7'h02, 8'h00);
            chk("ovl", i == 3, ovl);
        end
    endtask
    task automatic t_mem;
        for (int i = 0; i < 4; i++) begin
            put({4'hc, i[1:0], 10'h155}, 7'h08, 8'h00);
            chk("pg", 4'(~(4'h8 >> i)), pg);
            chk("ms", 1'b1, ms);
            chk("we", {i != 2, i != 2}, {cs, we});
            chk("ra", 10'h155, ra);
        end
        put(16'hc955, 7'h00, 8'h00);
        chk("rd", 2'h1, {cs, we});
        put(16'hd000, 7'h00, 8'h00);
        chk("d0", 5'h0f, {ms, pg});
        put(16'hc800, 7'h40, 8'h00);
        chk("io", 4'hf, pg);
    endtask
    task automatic t_ports;
        for (int p = 0; p < 8; p++) begin
            put({5'h1f, p[2:0], 8'h00}, 7'h42, 8'h00);
            chk("in", 8'(~(8'h1 << p)), pin);
            chk("isel", p < 4, isel);
            chk("ins", {p==7, p==6, p==4, p==5, p==5, p==3, p==2, p==1, p==0}, ins);
            put({5'h1f, p[2:0], 8'h00}, 7'h21, {3'h0, p == 0, 4'h0});
            chk("out", 8'(~(8'h1 << p)), pout);
            chk("outs", {p==6, p==5, p==3, p==2, p==1}, outs);
            chk("rts", 1'b1, rts);
        end
        put(16'hf000, 7'h42, 8'h00);
        chk("f0", 8'hff, pin);
        put(16'hfd00, 7'h52, 8'h00);
        chk("inta", 8'hff, pin);
    endtask
    task automatic t_wait;
        for (int k = 0; k < 3; k++) begin
            put(k == 0 ? 16'hc800 : k == 1 ? 16'hf900 : 16'h1000, k == 1 ? 7'h40 : 7'h00, 8'h00);
            go = 1'b1;
            @(posedge clk);
            #1;
            go = 1'b0;
            repeat (10) @(posedge clk);
            #1;
            chk("wait", {k < 2, 1'b1}, {wt, rdy});
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rstn = 1'b1;
        repeat (2) @(posedge clk);
        t_boot();
        t_mem();
        t_ports();
        t_wait();
        conclude();
    end
endmodule
